// File: rtl/pmc_cfg.svh
// Offsets, field positions, reset values and timing counts of the power-mode controller
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH
// Register byte addresses
`define PMC_ADDR_MODE 8'h00
`define PMC_ADDR_ACT_TPL 8'h04
`define PMC_ADDR_ALT_TPL 8'h08
`define PMC_ADDR_REG_EN 8'h0c
`define PMC_ADDR_STATUS 8'h10
`define PMC_ADDR_INT_STAT 8'h14
`define PMC_ADDR_INT_MASK 8'h18
`define PMC_ADDR_WAKE_SRC 8'h1c
// Template layout: bit 0 is the CPU
`define PMC_TPL_CPU 0
`define PMC_TPL_RESET 16'hffff
// Regulator enables: bit 0 digital, bit 1 analog
`define PMC_REG_EN_RESET 2'h3
// Interrupt status bits
`define PMC_INT_WAKE 0
`define PMC_INT_ABORT 1
`define PMC_INT_ENTERED 2
// Wake source bits
`define PMC_WK_COMP 0
`define PMC_WK_PIN 1
`define PMC_WK_I2C 2
`define PMC_WK_RTC 3
`define PMC_WK_TIMEWHEEL 4
`define PMC_WK_LVD 5
// Timing
`define PMC_CLK_MHZ 40
`define PMC_SLEEP_WAKE_NS 15000
`define PMC_HIB_WAKE_NS 100000
`define PMC_ENTRY_CYCLES 16
`define PMC_WAKE_MARGIN 8
`endif

// File: rtl/pmc_gate.sv
// Per-subsystem enable resolution from mode, templates and CPU override
`timescale 1ns/1ps
`include "pmc_cfg.svh"
module pmc_gate
  import pmc_pkg::*;
#(
  parameter int NSUB = 16
) (
  // Mode state
  input wire pmc_pkg::pmc_mode_t mode,
  input wire logic cpu_force,
  // Templates
  input wire logic [NSUB-1:0] act_tpl,
  input wire logic [NSUB-1:0] alt_tpl,
  // Result
  output logic [NSUB-1:0] sub_en
);
  always_comb begin
    case (mode)
      PMC_ACTIVE: sub_en = act_tpl; // R02
      PMC_ALT_ACTIVE: sub_en = alt_tpl; // R08
      PMC_SLEEP: sub_en = '0; // R10
      PMC_HIBERNATE: sub_en = '0; // R13
      default: sub_en = '0;
    endcase
    // A wakeup turns the CPU on whatever its template says
    if (cpu_force && (mode == PMC_ACTIVE)) begin
      sub_en[`PMC_TPL_CPU] = 1'b1; // R06
    end
  end
endmodule : pmc_gate

// File: rtl/pmc_pkg.sv
// Types shared by the power-mode controller files
package pmc_pkg;
  typedef enum logic [1:0] {
    PMC_ACTIVE,
    PMC_ALT_ACTIVE,
    PMC_SLEEP,
    PMC_HIBERNATE
  } pmc_mode_t;

  typedef struct packed {
    logic comparator;
    logic pin_interrupt_unit;
    logic i2c;
    logic rtc;
    logic central_timewheel;
    logic low_voltage_detect;
  } pmc_wake_t;

  typedef struct packed {
    logic hibernate_reg;
    logic sleep_reg;
    logic digital_reg;
    logic analog_reg;
  } pmc_reg_t;
endpackage : pmc_pkg

// File: rtl/pmc_sync.sv
// Three-stage synchroniser for pin-side inputs, change accepted when the last two stages agree
`timescale 1ns/1ps
module pmc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1, s2, s3;
  logic [WIDTH-1:0] next_dout;

  always_comb begin
    next_dout = dout;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2[i] == s3[i]) begin
        next_dout[i] = s3[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      dout <= '0;
    end else begin
      s1 <= din;
      s2 <= s1;
      s3 <= s2;
      dout <= next_dout;
    end
  end
endmodule : pmc_sync

// File: rtl/pmc_top.sv
// Global power-mode controller with template gating and wakeup handling
//
// Function
// (R01) Four modes: active, alternate active, sleep, hibernate, by falling power.
// (R02) In active each subsystem follows its own active template bit.
// (R03) Disabled subsystem has clocks gated and analog bias turned off.
// (R04) Template bits may change any time; subsystem enables follow at once.
// (R05) CPU may switch itself off; next wakeup turns it back on.
// (R06) Wakeup sets mode active and enables CPU over its template bit.
// (R07) After reset the mode is active.
// (R08) Alternate active uses a separate template, otherwise like active.
// (R09) Only active is entered by wakeup/reset; lower modes by register write.
// (R10) Sleep disables most resources; timers run; resume under 15 us.
// (R11) Sleep wakes only on comparator, pins, I2C, RTC, timewheel, LOW_VOLTAGE_DETECT.
// (R12) Hibernate retains state, stops clocks, wakes on pins, under 100 us.
// (R13) Hibernate leaves only the hibernate regulator on; peripherals off.
// (R14) Firmware waits for valid I/O supplies before sleep or hibernate.
// (R15) Internal regulator enables default on; firmware may clear them.
// (R16) Mode write starts entry; a wakeup during entry aborts to active.
`include "pmc_cfg.svh"
`timescale 1ns/1ps
module pmc_top
  import pmc_pkg::*;
#(
  parameter int NSUB = 16,
  parameter int ENTRY_CYCLES = `PMC_ENTRY_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Wakeup sources, interrupt and supply flag (asynchronous)
  input wire pmc_pkg::pmc_wake_t wake_in,
  input wire logic any_irq,
  input wire logic io_supply_ok,
  // Power controls
  output logic [NSUB-1:0] sub_clk_en,
  output logic [NSUB-1:0] sub_bias_en,
  output pmc_pkg::pmc_reg_t reg_ctl,
  output pmc_pkg::pmc_mode_t mode_out,
  output logic lowspeed_osc_only,
  output logic all_clk_stop,
  output logic timed_sleep_run,
  output logic irq
);
  import pmc_pkg::*;

  // ==========================================================
  // Timing
  // ==========================================================
  // Margin covers synchroniser and output stages so the whole resume,
  // not just the settle count, stays under the limit
  localparam int SLEEP_WAKE_CYC =
    (`PMC_SLEEP_WAKE_NS * `PMC_CLK_MHZ) / 1000 - `PMC_WAKE_MARGIN;
  localparam int HIB_WAKE_CYC =
    (`PMC_HIB_WAKE_NS * `PMC_CLK_MHZ) / 1000 - `PMC_WAKE_MARGIN;
  localparam int CW = 13;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_ENTER,
    ST_LOW,
    ST_RESUME
  } pmc_state_t;

  // ==========================================================
  // Input synchronisation
  // ==========================================================
  logic [7:0] wake_raw;
  logic [7:0] wake_sync;
  pmc_wake_t wk;
  logic irq_s;
  logic supply_s;

  // Supply flag is a pin level too, so it shares the synchroniser
  assign wake_raw = {io_supply_ok, any_irq, wake_in};

  pmc_sync #(.WIDTH(8)) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din(wake_raw),
    .dout(wake_sync)
  );

  assign wk = wake_sync[5:0];
  assign irq_s = wake_sync[6];
  assign supply_s = wake_sync[7];

  // ==========================================================
  // State
  // ==========================================================
  pmc_state_t state, next_state;
  pmc_mode_t mode, next_mode;
  pmc_mode_t target, next_target;
  logic [CW-1:0] cnt, next_cnt;
  logic cpu_force, next_cpu_force;
  logic [NSUB-1:0] act_tpl, next_act_tpl;
  logic [NSUB-1:0] alt_tpl, next_alt_tpl;
  logic [1:0] reg_en, next_reg_en;
  logic [2:0] int_stat, next_int_stat;
  logic [2:0] int_mask, next_int_mask;
  logic [5:0] last_wake, next_last_wake;
  logic [31:0] next_rdata;
  logic wake_ev;
  logic [NSUB-1:0] sub_en;
  logic [2:0] ev;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction : hit

  // Wakeup qualification by the mode being left or entered
  always_comb begin
    case ((state == ST_ENTER || state == ST_LOW) ? target : mode)
      PMC_ACTIVE: wake_ev = irq_s; // R09
      PMC_ALT_ACTIVE: wake_ev = irq_s; // R09
      PMC_SLEEP: wake_ev = |wk; // R11
      PMC_HIBERNATE: wake_ev = wk.pin_interrupt_unit; // R12
      default: wake_ev = 1'b0;
    endcase
  end

  always_comb begin
    next_state = state;
    next_mode = mode;
    next_target = target;
    next_cnt = cnt;
    next_cpu_force = cpu_force;
    ev = 3'h0;
    case (state)
      ST_RUN: begin
        // Rewriting the active template hands the CPU back to its bit
        if (reg_wr && hit(reg_addr, `PMC_ADDR_ACT_TPL)) begin
          next_cpu_force = 1'b0; // R04
        end
        // Wakeup while running re-enables a CPU that switched itself off
        if (wake_ev && mode == PMC_ACTIVE) begin
          next_cpu_force = 1'b1; // R05
          ev[`PMC_INT_WAKE] = 1'b1;
        end
        if (wake_ev && mode == PMC_ALT_ACTIVE) begin
          next_mode = PMC_ACTIVE; // R06
          next_cpu_force = 1'b1; // R06
          ev[`PMC_INT_WAKE] = 1'b1;
        end else if (reg_wr && hit(reg_addr, `PMC_ADDR_MODE)) begin
          case (pmc_mode_t'(reg_wdata[1:0]))
            PMC_ACTIVE: begin
              next_mode = PMC_ACTIVE; // R09
            end
            PMC_ALT_ACTIVE: begin
              next_mode = PMC_ALT_ACTIVE; // R09
              next_cpu_force = 1'b0;
            end
            default: begin
              next_target = pmc_mode_t'(reg_wdata[1:0]);
              next_state = ST_ENTER; // R16
              next_cnt = CW'(ENTRY_CYCLES - 1);
            end
          endcase
        end
      end
      ST_ENTER: begin
        if (wake_ev) begin
          next_state = ST_RUN; // R16
          next_mode = PMC_ACTIVE;
          next_cpu_force = 1'b1;
          ev[`PMC_INT_ABORT] = 1'b1;
        end else if (cnt == '0) begin
          next_state = ST_LOW;
          next_mode = target; // R01
          ev[`PMC_INT_ENTERED] = 1'b1;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      ST_LOW: begin
        if (wake_ev) begin
          next_state = ST_RESUME;
          next_cnt = (mode == PMC_SLEEP) ?
            CW'(SLEEP_WAKE_CYC) : CW'(HIB_WAKE_CYC); // R10 R12
        end
      end
      ST_RESUME: begin
        if (cnt == '0) begin
          next_state = ST_RUN;
          next_mode = PMC_ACTIVE; // R06
          next_cpu_force = 1'b1; // R05
          ev[`PMC_INT_WAKE] = 1'b1;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: begin
        next_state = ST_RUN;
        next_mode = PMC_ACTIVE;
      end
    endcase
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_comb begin
    next_act_tpl = act_tpl;
    next_alt_tpl = alt_tpl;
    next_reg_en = reg_en;
    next_int_mask = int_mask;
    next_int_stat = int_stat;
    next_last_wake = last_wake;
    next_rdata = 32'h0;
    if (reg_wr) begin
      if (hit(reg_addr, `PMC_ADDR_ACT_TPL)) begin
        next_act_tpl = reg_wdata[NSUB-1:0]; // R04
      end
      if (hit(reg_addr, `PMC_ADDR_ALT_TPL)) begin
        next_alt_tpl = reg_wdata[NSUB-1:0]; // R04
      end
      if (hit(reg_addr, `PMC_ADDR_REG_EN)) begin
        next_reg_en = reg_wdata[1:0]; // R15
      end
      if (hit(reg_addr, `PMC_ADDR_INT_MASK)) begin
        next_int_mask = reg_wdata[2:0];
      end
      if (hit(reg_addr, `PMC_ADDR_INT_STAT)) begin
        next_int_stat = int_stat & ~reg_wdata[2:0];
      end
    end
    // Set beats clear so an event in the clearing cycle survives
    next_int_stat = next_int_stat | ev;
    if (wake_ev && state != ST_RUN) begin
      next_last_wake = wk;
    end
    if (reg_rd) begin
      case (reg_addr)
        `PMC_ADDR_MODE: next_rdata = {30'h0, mode};
        `PMC_ADDR_ACT_TPL: next_rdata = 32'(act_tpl);
        `PMC_ADDR_ALT_TPL: next_rdata = 32'(alt_tpl);
        `PMC_ADDR_REG_EN: next_rdata = {30'h0, reg_en};
        `PMC_ADDR_STATUS: next_rdata = {27'h0, supply_s, cpu_force,
                                        state};
        `PMC_ADDR_INT_STAT: next_rdata = {29'h0, int_stat};
        `PMC_ADDR_INT_MASK: next_rdata = {29'h0, int_mask};
        `PMC_ADDR_WAKE_SRC: next_rdata = {26'h0, last_wake};
        default: next_rdata = 32'h0;
      endcase
    end
  end

  pmc_gate #(.NSUB(NSUB)) u_gate (
    .mode(mode),
    .cpu_force(cpu_force),
    .act_tpl(act_tpl),
    .alt_tpl(alt_tpl),
    .sub_en(sub_en)
  );

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state <= ST_RUN;
      mode <= PMC_ACTIVE; // R07
      target <= PMC_ACTIVE;
      cnt <= '0;
      cpu_force <= 1'b0;
      act_tpl <= NSUB'(`PMC_TPL_RESET);
      alt_tpl <= NSUB'(`PMC_TPL_RESET);
      reg_en <= `PMC_REG_EN_RESET; // R15
      int_stat <= 3'h0;
      int_mask <= 3'h0;
      last_wake <= 6'h0;
      reg_rdata <= 32'h0;
      sub_clk_en <= '0;
      sub_bias_en <= '0;
      reg_ctl <= '0;
      mode_out <= PMC_ACTIVE;
      lowspeed_osc_only <= 1'b0;
      all_clk_stop <= 1'b0;
      timed_sleep_run <= 1'b0;
      irq <= 1'b0;
    end else begin
      state <= next_state;
      mode <= next_mode;
      target <= next_target;
      cnt <= next_cnt;
      cpu_force <= next_cpu_force;
      act_tpl <= next_act_tpl;
      alt_tpl <= next_alt_tpl;
      reg_en <= next_reg_en;
      int_stat <= next_int_stat;
      int_mask <= next_int_mask;
      last_wake <= next_last_wake;
      reg_rdata <= next_rdata;
      sub_clk_en <= sub_en; // R03
      sub_bias_en <= sub_en; // R03
      reg_ctl.hibernate_reg <= 1'b1;
      reg_ctl.sleep_reg <= (mode == PMC_SLEEP);
      reg_ctl.digital_reg <= reg_en[0] && (mode != PMC_HIBERNATE); // R13
      reg_ctl.analog_reg <= reg_en[1] && (mode != PMC_HIBERNATE); // R13
      mode_out <= mode;
      lowspeed_osc_only <= (mode == PMC_SLEEP); // R11
      all_clk_stop <= (mode == PMC_HIBERNATE); // R12
      timed_sleep_run <= (mode != PMC_HIBERNATE); // R10
      irq <= |(next_int_stat & int_mask);
    end
  end
endmodule : pmc_top

// File: verification/pmc_top_properties.sv
// Port-level properties of the power-mode controller
`timescale 1ns/1ps
`include "pmc_cfg.svh"
module pmc_top_properties
  import pmc_pkg::*;
#(
  parameter int NSUB = 16
) (
  // Clock, reset and register port
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Power controls
  input wire logic [NSUB-1:0] sub_clk_en,
  input wire logic [NSUB-1:0] sub_bias_en,
  input wire pmc_pkg::pmc_reg_t reg_ctl,
  input wire pmc_pkg::pmc_mode_t mode_out,
  input wire logic lowspeed_osc_only,
  input wire logic all_clk_stop,
  input wire logic timed_sleep_run,
  input wire logic irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ==========
  // Assertions and cover points
  a_reset_active: assert property (disable iff (1'b0)
    $fell(rst) |-> (mode_out == PMC_ACTIVE) [*4])
    else $error("mode not active after reset");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == '0)
    else $error("read data not zero outside read answer");
  a_mask_clear_irq: assert property (
    reg_wr && reg_addr == `PMC_ADDR_INT_MASK && reg_wdata[2:0] == 3'h0
    ##1 !reg_wr |-> ##1 !irq)
    else $error("irq high with all events masked");
  a_clk_bias_pair: assert property (sub_clk_en == sub_bias_en)
    else $error("clock and bias enables disagree");
  a_sleep_gated: assert property (
    mode_out == PMC_SLEEP && $stable(mode_out) |->
    sub_clk_en == '0 && lowspeed_osc_only && timed_sleep_run)
    else $error("sleep left resources running");
  a_hib_off: assert property (
    mode_out == PMC_HIBERNATE && $stable(mode_out) |->
    reg_ctl == 4'h8 && all_clk_stop && sub_clk_en == '0 && !timed_sleep_run)
    else $error("hibernate left clocks or regulators on");
  a_wake_active: assert property (
    $past(mode_out) inside {PMC_SLEEP, PMC_HIBERNATE} && $changed(mode_out)
    |-> mode_out == PMC_ACTIVE)
    else $error("low mode left to a mode other than active");
  a_wake_cpu_on: assert property (
    $past(mode_out) == PMC_SLEEP && mode_out == PMC_ACTIVE
    |-> ##[0:1] sub_clk_en[0])
    else $error("cpu not enabled after wakeup");
  c_sleep: cover property (mode_out == PMC_SLEEP);
  c_hib: cover property (mode_out == PMC_HIBERNATE);
  c_alt: cover property (mode_out == PMC_ALT_ACTIVE);
endmodule : pmc_top_properties

bind pmc_top pmc_top_properties #(.NSUB(NSUB)) u_pmc_top_properties (
  .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .sub_clk_en(sub_clk_en),
  .sub_bias_en(sub_bias_en), .reg_ctl(reg_ctl), .mode_out(mode_out),
  .lowspeed_osc_only(lowspeed_osc_only), .all_clk_stop(all_clk_stop),
  .timed_sleep_run(timed_sleep_run), .irq(irq));

// File: verification/tb_top.sv
// Self-checking bench for the power-mode controller
`timescale 1ns/1ps
`include "pmc_cfg.svh"
module tb_top;
  import pmc_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  pmc_wake_t wake_in = '0;
  logic any_irq = 1'b0;
  logic io_supply_ok = 1'b1;
  logic [15:0] sub_clk_en;
  logic [15:0] sub_bias_en;
  pmc_reg_t reg_ctl;
  pmc_mode_t mode_out;
  logic lowspeed_osc_only;
  logic all_clk_stop;
  logic timed_sleep_run;
  logic irq;
  logic [31:0] rd_val;
  int err_count = 0;
  int n_tests = 0;
  int n_wait = 0;

  always #12.5 clk_sys = ~clk_sys;

  // Short entry count keeps the low-mode scenarios brief
  pmc_top #(.NSUB(16), .ENTRY_CYCLES(2)) u_pmc_top (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .wake_in(wake_in), .any_irq(any_irq),
    .io_supply_ok(io_supply_ok), .sub_clk_en(sub_clk_en),
    .sub_bias_en(sub_bias_en), .reg_ctl(reg_ctl), .mode_out(mode_out),
    .lowspeed_osc_only(lowspeed_osc_only), .all_clk_stop(all_clk_stop),
    .timed_sleep_run(timed_sleep_run), .irq(irq));

  // ==========
  // Bus and check helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : settle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 rd_val = reg_rdata;
  endtask : rd

  // Bounded wait for a mode, then compare
  task automatic wait_mode(input pmc_mode_t m, input int n);
    int i;
    for (i = 0; i < n && mode_out !== m; i++) begin
      settle(1);
    end
    n_wait = i;
    chk(mode_out, m);
  endtask : wait_mode

  // ==========
  // Scenarios
  task automatic t_reset();
    chk(mode_out, PMC_ACTIVE);
    chk(sub_clk_en, 16'hffff);
    chk(reg_ctl, 4'hb);
    rd(`PMC_ADDR_REG_EN);
    chk(rd_val, 32'h3);
    wr(`PMC_ADDR_REG_EN, 32'h0);
    settle(3);
    chk(reg_ctl, 4'h8);
    wr(`PMC_ADDR_REG_EN, 32'h3);
    rd(`PMC_ADDR_STATUS);
    chk(rd_val & 32'h17, 32'h10);
    wr(8'h20, 32'hffffffff);
    rd(8'h20);
    chk(rd_val, 32'h0);
  endtask : t_reset

  task automatic t_templates();
    wr(`PMC_ADDR_ACT_TPL, 32'h5a5b);
    settle(3);
    chk(sub_clk_en, 16'h5a5b);
    chk(sub_bias_en, 16'h5a5b);
    wr(`PMC_ADDR_ALT_TPL, 32'h00f0);
    wr(`PMC_ADDR_MODE, 32'h1);
    wait_mode(PMC_ALT_ACTIVE, 4);
    rd(`PMC_ADDR_MODE);
    chk(rd_val, 32'h1);
    settle(2);
    chk(sub_clk_en, 16'h00f0);
    wr(`PMC_ADDR_ACT_TPL, 32'h00fe);
    wr(`PMC_ADDR_MODE, 32'h0);
    wait_mode(PMC_ACTIVE, 4);
    settle(2);
    chk(sub_clk_en, 16'h00fe);
  endtask : t_templates

  task automatic t_sleep();
    wr(`PMC_ADDR_INT_MASK, 32'h5);
    wr(`PMC_ADDR_MODE, 32'h2);
    wait_mode(PMC_SLEEP, 8);
    settle(1);
    chk({lowspeed_osc_only, timed_sleep_run, sub_clk_en}, 18'h30000);
    chk(reg_ctl, 4'hf);
    chk(irq, 1'b1);
    wr(`PMC_ADDR_INT_MASK, 32'h0);
    settle(2);
    chk(irq, 1'b0);
    wr(`PMC_ADDR_INT_STAT, 32'h4);
    wr(`PMC_ADDR_INT_MASK, 32'h1);
    // A plain interrupt must not end sleep
    any_irq <= 1'b1;
    settle(700);
    chk(mode_out, PMC_SLEEP);
    @(posedge clk_sys);
    any_irq <= 1'b0;
    wake_in <= 6'h04;
    wait_mode(PMC_ACTIVE, 700);
    chk(n_wait < `PMC_SLEEP_WAKE_NS * `PMC_CLK_MHZ / 1000, 1'b1);
    settle(2);
    chk(sub_clk_en[0], 1'b1);
    chk(irq, 1'b1);
    rd(`PMC_ADDR_STATUS);
    chk(rd_val & 32'h8, 32'h8);
    rd(`PMC_ADDR_WAKE_SRC);
    chk(rd_val, 32'h4);
    @(posedge clk_sys);
    wake_in <= '0;
    wr(`PMC_ADDR_INT_STAT, 32'h7);
    // Rewriting the template hands the CPU back to its own bit
    wr(`PMC_ADDR_ACT_TPL, 32'h00fe);
    settle(2);
    chk(sub_clk_en[0], 1'b0);
  endtask : t_sleep

  task automatic t_hib();
    wr(`PMC_ADDR_MODE, 32'h3);
    wait_mode(PMC_HIBERNATE, 8);
    settle(1);
    chk({reg_ctl, all_clk_stop, sub_clk_en}, 21'h110000);
    @(posedge clk_sys);
    wake_in <= 6'h04;
    settle(4100);
    chk(mode_out, PMC_HIBERNATE);
    @(posedge clk_sys);
    wake_in <= 6'h10;
    wait_mode(PMC_ACTIVE, 4100);
    chk(n_wait < `PMC_HIB_WAKE_NS * `PMC_CLK_MHZ / 1000, 1'b1);
    rd(`PMC_ADDR_WAKE_SRC);
    chk(rd_val, 32'h10);
    @(posedge clk_sys);
    wake_in <= '0;
    wr(`PMC_ADDR_INT_STAT, 32'h7);
  endtask : t_hib

  // Wake source already present when entry starts
  task automatic t_abort();
    wr(`PMC_ADDR_INT_MASK, 32'h2);
    wake_in <= 6'h20;
    settle(8);
    wr(`PMC_ADDR_MODE, 32'h2);
    settle(10);
    chk(mode_out, PMC_ACTIVE);
    chk(irq, 1'b1);
    @(posedge clk_sys);
    wake_in <= '0;
  endtask : t_abort

  task automatic give_verdict();
    if (err_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    settle(2);
    t_reset();
    t_templates();
    t_sleep();
    t_hib();
    t_abort();
    give_verdict();
  end

  // Run needs about 10k cycles; 40k is a hang
  initial begin
    #1000000;
    err_count++;
    give_verdict();
  end
endmodule : tb_top
